// ===== logic/tm3_pkg.sv
// constants shared by the auto-reload timer control block
package tm3_pkg;
   // register addresses on the special function register bus
   localparam logic [7:0] ADDR_CONTROL     = 8'h91;
   localparam logic [7:0] ADDR_RELOAD_LOW  = 8'h92;
   localparam logic [7:0] ADDR_RELOAD_HIGH = 8'h93;
   localparam logic [7:0] ADDR_COUNT_LOW   = 8'h94;
   localparam logic [7:0] ADDR_COUNT_HIGH  = 8'h95;
   // timer_control field positions
   localparam int BIT_SPLIT = 3;
   localparam int BIT_RUN   = 2;
   localparam int BIT_XCLK  = 0;
   // reset values
   localparam logic [7:0] RST_CONTROL = 8'h00;
   localparam logic [7:0] RST_BYTE    = 8'h00;
   // clock prescale counts
   localparam int SYS_DIV = 12;
   localparam int EXT_DIV = 8;
endpackage

// ===== logic/tm3_ext_tick.sv
// external oscillator synchroniser and divide-by-n tick generator
`timescale 1ns/1ps
module tm3_ext_tick #(
   parameter int DIV = tm3_pkg::EXT_DIV
) (
   input  wire logic ref_clk,  // system clock
   input  wire logic rst,      // synchronous reset, active high
   input  wire logic ext_osc,  // external oscillator pin, asynchronous
   output logic      tick      // one-cycle pulse every DIV oscillator rises
);
   localparam int CW = $clog2(DIV);

   logic          sync1;
   logic          sync2;
   logic          sync3;
   logic          level;
   logic [CW-1:0] count;
   logic          next_level;
   logic [CW-1:0] next_count;
   logic          next_tick;

   if (DIV < 2)
   begin : g_bad_div
      $error("tm3_ext_tick: DIV must be at least 2");
   end

   // oscillator must stay at or below a quarter of the system clock to be seen at all
   always_comb
   begin
      next_level = level;
      next_count = count;
      next_tick  = 1'b0;
      if (sync2 == sync3)
         next_level = sync3;
      if (next_level && !level)                                         // RL4
      begin
         if (count == CW'(DIV - 1))                                     // RL3
         begin
            next_count = '0;
            next_tick  = 1'b1;
         end
         else
            next_count = count + CW'(1);
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         sync1 <= 1'b0;
         sync2 <= 1'b0;
         sync3 <= 1'b0;
         level <= 1'b0;
         count <= '0;
         tick  <= 1'b0;
      end
      else
      begin
         sync1 <= ext_osc;
         sync2 <= sync1;
         sync3 <= sync2;
         level <= next_level;
         count <= next_count;
         tick  <= next_tick;
      end
   end
endmodule // tm3_ext_tick

// ===== logic/tm3_timer.sv
// auto-reload timer with run control, split mode and clock selection
// Summary of operation
// RL1: timer counts only while run bit set, except the low byte in split mode
// RL2: split mode: run gates high byte only
// RL3: external select 1 picks oscillator divided by 8
// RL4: divided oscillator synchronised to system clock
// RL5: reload low byte register at 0x92
// RL6: split bit picks 16-bit or two 8-bit
// RL7: select 0 gives sysclk/12; per-byte clock choice
`timescale 1ns/1ps
module tm3_timer #(
   parameter int SYS_DIV = tm3_pkg::SYS_DIV,  // system clock prescale for the divided choice
   parameter int EXT_DIV = tm3_pkg::EXT_DIV   // external oscillator prescale
) (
   input  wire logic       ref_clk,        // system clock, 20 MHz
   input  wire logic       rst,            // synchronous reset, active high
   input  wire logic [7:0] sfr_addr,       // register address
   input  wire logic       sfr_wr,         // write strobe, one cycle
   input  wire logic [7:0] sfr_wdata,      // write data
   input  wire logic       sfr_rd,         // read strobe, one cycle
   output logic      [7:0] sfr_rdata,      // read data, valid cycle after sfr_rd
   input  wire logic       clk_sel_low,    // clock_control_register bit, low byte: 1 = system clock
   input  wire logic       clk_sel_high,   // clock_control_register bit, high byte: 1 = system clock
   input  wire logic       ext_osc,        // external oscillator pin
   output logic            ovf_low,        // low byte overflow pulse (split mode)
   output logic            ovf_high        // high byte / 16-bit overflow pulse
);
   // only the three defined control bits are stored; the others read back as zero
   localparam logic [7:0] CTRL_WMASK = (8'h01 << tm3_pkg::BIT_SPLIT) | (8'h01 << tm3_pkg::BIT_RUN)
                                     | (8'h01 << tm3_pkg::BIT_XCLK);

   logic [7:0] timer_control;
   logic [7:0] reload_value_low;
   logic [7:0] reload_value_high;
   logic [7:0] counter_low_byte;
   logic [7:0] counter_high_byte;
   logic [3:0] pre_count;
   logic [7:0] next_control;
   logic [7:0] next_reload_low;
   logic [7:0] next_reload_high;
   logic [7:0] next_count_low;
   logic [7:0] next_count_high;
   logic [3:0] next_pre_count;
   logic [7:0] next_rdata;
   logic       next_ovf_low;
   logic       next_ovf_high;
   logic       sys12_tick;
   logic       ext8_tick;
   logic       ext_choice;
   logic       step_low;
   logic       step_high;
   logic       run_control_bit;
   logic       split_mode_bit;
   logic       external_clock_select_bit;
   logic       low_full;
   logic       high_full;
   logic       go_low;
   logic       go_high;
   logic [1:0] byte_clk_sel;
   logic [1:0] byte_step;

   assign run_control_bit           = timer_control[tm3_pkg::BIT_RUN];
   assign split_mode_bit            = timer_control[tm3_pkg::BIT_SPLIT];
   assign external_clock_select_bit = timer_control[tm3_pkg::BIT_XCLK];

   // the 4-bit prescaler cannot count further than 16
   if (SYS_DIV < 2 || SYS_DIV > 16)
   begin : g_bad_sys_div
      $error("tm3_timer: SYS_DIV must lie between 2 and 16");
   end
   if (EXT_DIV < 2)
   begin : g_bad_ext_div
      $error("tm3_timer: EXT_DIV must be at least 2");
   end
   // field positions must fit inside the control byte
   if (tm3_pkg::BIT_SPLIT > 7 || tm3_pkg::BIT_RUN > 7 || tm3_pkg::BIT_XCLK > 7)
   begin : g_bad_field
      $error("tm3_timer: control field lies outside the byte");
   end

   tm3_ext_tick #(
      .DIV     (EXT_DIV)
   ) i_tm3_ext_tick (
      .ref_clk (ref_clk),
      .rst     (rst),
      .ext_osc (ext_osc),
      .tick    (ext8_tick)
   );

   // prescaler runs free so the first tick after start is not aligned
   always_comb
   begin
      sys12_tick     = (pre_count == 4'(SYS_DIV - 1));
      next_pre_count = sys12_tick ? 4'h0 : pre_count + 4'h1;
   end

   assign ext_choice   = external_clock_select_bit ? ext8_tick : sys12_tick;   // RL3 RL7
   assign byte_clk_sel = {clk_sel_high, clk_sel_low};

   // each byte picks the system clock or the shared divided choice on its own
   for (genvar b = 0; b < 2; b++)
   begin : g_byte_step
      assign byte_step[b] = byte_clk_sel[b] ? 1'b1 : ext_choice;         // RL7
   end

   always_comb
   begin
      step_low  = byte_step[0];
      step_high = byte_step[1];
      // in split mode the low byte keeps counting whatever the run bit says
      go_low    = step_low && (split_mode_bit || run_control_bit);       // RL1 RL2
      go_high   = step_high && run_control_bit;                          // RL1 RL2
      low_full  = (counter_low_byte == 8'hFF);
      high_full = (counter_high_byte == 8'hFF);
   end

   always_comb
   begin
      next_control     = timer_control;
      next_reload_low  = reload_value_low;
      next_reload_high = reload_value_high;
      next_count_low   = counter_low_byte;
      next_count_high  = counter_high_byte;
      next_ovf_low     = 1'b0;
      next_ovf_high    = 1'b0;
      if (split_mode_bit)                                               // RL6
      begin
         if (go_low)                                                    // RL2
         begin
            if (low_full)
            begin
               next_count_low = reload_value_low;
               next_ovf_low   = 1'b1;
            end
            else
               next_count_low = counter_low_byte + 8'h01;
         end
         if (go_high)                                                   // RL2 RL1
         begin
            if (high_full)
            begin
               next_count_high = reload_value_high;
               next_ovf_high   = 1'b1;
            end
            else
               next_count_high = counter_high_byte + 8'h01;
         end
      end
      else if (go_low)                                                  // RL1 RL6
      begin
         if (high_full && low_full)
         begin
            next_count_low  = reload_value_low;
            next_count_high = reload_value_high;
            next_ovf_high   = 1'b1;
         end
         else
            {next_count_high, next_count_low} = {counter_high_byte, counter_low_byte} + 16'h0001;
      end
      // a software write to a counter byte wins over counting
      if (sfr_wr)
      begin
         unique case (sfr_addr)
            tm3_pkg::ADDR_CONTROL:
               next_control = sfr_wdata & CTRL_WMASK;
            tm3_pkg::ADDR_RELOAD_LOW:
               next_reload_low = sfr_wdata;                             // RL5
            tm3_pkg::ADDR_RELOAD_HIGH:
               next_reload_high = sfr_wdata;
            tm3_pkg::ADDR_COUNT_LOW:
               next_count_low = sfr_wdata;
            tm3_pkg::ADDR_COUNT_HIGH:
               next_count_high = sfr_wdata;
            default:
               next_control = timer_control;
         endcase
      end
   end

   always_comb
   begin
      next_rdata = sfr_rdata;
      if (sfr_rd)
      begin
         unique case (sfr_addr)
            tm3_pkg::ADDR_CONTROL:     next_rdata = timer_control;
            tm3_pkg::ADDR_RELOAD_LOW:  next_rdata = reload_value_low;   // RL5
            tm3_pkg::ADDR_RELOAD_HIGH: next_rdata = reload_value_high;
            tm3_pkg::ADDR_COUNT_LOW:   next_rdata = counter_low_byte;
            tm3_pkg::ADDR_COUNT_HIGH:  next_rdata = counter_high_byte;
            default:                   next_rdata = 8'h00;
         endcase
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         timer_control     <= tm3_pkg::RST_CONTROL;
         reload_value_low  <= tm3_pkg::RST_BYTE;
         reload_value_high <= tm3_pkg::RST_BYTE;
         counter_low_byte  <= tm3_pkg::RST_BYTE;
         counter_high_byte <= tm3_pkg::RST_BYTE;
         pre_count         <= 4'h0;
         sfr_rdata         <= tm3_pkg::RST_BYTE;
         ovf_low           <= 1'b0;
         ovf_high          <= 1'b0;
      end
      else
      begin
         timer_control     <= next_control;
         reload_value_low  <= next_reload_low;
         reload_value_high <= next_reload_high;
         counter_low_byte  <= next_count_low;
         counter_high_byte <= next_count_high;
         pre_count         <= next_pre_count;
         sfr_rdata         <= next_rdata;
         ovf_low           <= next_ovf_low;
         ovf_high          <= next_ovf_high;
      end
   end
endmodule // tm3_timer

// ===== sim/tm3_timer_props.sv
// concurrent checks on the timer control block ports
`timescale 1ns/1ps
module tm3_props (
   input wire logic       ref_clk,      // clock
   input wire logic       rst,          // reset
   input wire logic [7:0] sfr_addr,     // address
   input wire logic       sfr_wr,       // write
   input wire logic [7:0] sfr_wdata,    // wdata
   input wire logic       sfr_rd,       // read
   input wire logic [7:0] sfr_rdata,    // rdata
   input wire logic       clk_sel_low,  // low sel
   input wire logic       clk_sel_high, // high sel
   input wire logic       ext_osc,      // osc pin
   input wire logic       ovf_low,      // low ovf
   input wire logic       ovf_high      // high ovf
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);
   logic [7:0] ctl;
   logic [7:0] next_ctl;
   logic [3:0] quiet;
   logic [3:0] next_quiet;
   logic       osc_q;
   // control byte shadow rebuilt from bus writes
   always_comb
   begin
      next_ctl   = (sfr_wr && sfr_addr == tm3_pkg::ADDR_CONTROL) ? sfr_wdata : ctl;
      next_quiet = (ext_osc != osc_q) ? 4'h0 : quiet + {3'h0, quiet != 4'hf};
   end
   always_ff @(posedge ref_clk)
   begin
      ctl   <= rst ? 8'h00 : next_ctl;
      quiet <= rst ? 4'h0 : next_quiet;
      osc_q <= ext_osc;
   end
   sequence s_wr_rld;
      sfr_wr && sfr_addr == tm3_pkg::ADDR_RELOAD_LOW;
   endsequence
   sequence s_rd_rld;
      sfr_rd && !sfr_wr && sfr_addr == tm3_pkg::ADDR_RELOAD_LOW;
   endsequence
   a_reload_readback: assert property (s_wr_rld ##1 s_rd_rld |=> sfr_rdata == $past(sfr_wdata, 2))
      else $error("reload low readback differs");
   a_unmapped_zero: assert property (sfr_rd && !(sfr_addr inside {[8'h91:8'h95]})
      |=> sfr_rdata == 8'h00) else $error("unmapped read not zero");
   a_rdata_holds: assert property (!sfr_rd |=> $stable(sfr_rdata))
      else $error("read data moved without a read");
   a_run_gates_high: assert property (!ctl[tm3_pkg::BIT_RUN] [*3] |-> !ovf_high)
      else $error("high overflow while stopped");
   a_split_low_silent: assert property (!ctl[tm3_pkg::BIT_SPLIT] [*3] |-> !ovf_low)
      else $error("low overflow in 16-bit mode");
   a_ext_quiet: assert property ((ctl[tm3_pkg::BIT_XCLK] && !clk_sel_low) [*3] ##0 quiet == 4'hf
      |-> !ovf_low) else $error("low overflow with idle oscillator");
   a_ovf_single: assert property (ovf_low && !clk_sel_low ##1 !clk_sel_low |-> !ovf_low)
      else $error("divided clock stepped twice in a row");
endmodule // tm3_props
bind tm3_timer tm3_props i_tm3_props (.ref_clk, .rst, .sfr_addr, .sfr_wr, .sfr_wdata, .sfr_rd, .sfr_rdata,
   .clk_sel_low, .clk_sel_high, .ext_osc, .ovf_low, .ovf_high);

// ===== sim/tm3_timer_test.sv
// self-checking bench for the timer control block
`timescale 1ns/1ps
module tm3_timer_test;
   logic        ref_clk = 1'b0;
   logic        rst = 1'b1;
   logic [7:0]  sfr_addr = 8'h00;
   logic        sfr_wr = 1'b0;
   logic [7:0]  sfr_wdata = 8'h00;
   logic        sfr_rd = 1'b0;
   logic [7:0]  sfr_rdata;
   logic        clk_sel_low = 1'b1;
   logic        clk_sel_high = 1'b1;
   logic        ext_osc = 1'b0;
   logic        ovf_low;
   logic        ovf_high;
   logic        osc_en = 1'b0;
   logic [2:0]  osc_c = 3'h0;
   logic        pend = 1'b0;
   logic [31:0] seed = 32'hd489_493d;
   logic [7:0]  exp_q[$];
   int          n_mismatch = 0;
   int          n_compared = 0;
   int          n_lo = 0;
   int          n_hi = 0;
   int          cyc = 0;
   tm3_timer i_tm3_timer (.ref_clk, .rst, .sfr_addr, .sfr_wr, .sfr_wdata, .sfr_rd, .sfr_rdata,
      .clk_sel_low, .clk_sel_high, .ext_osc, .ovf_low, .ovf_high);
   always #25 ref_clk = ~ref_clk;
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic print_verdict();
      $display("compared %0d mismatched %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic chk_byte(input logic [7:0] got, input logic [7:0] want);
      n_compared++;
      if (got !== want)
      begin
         n_mismatch++;
         $display("[FAIL] %0t got %h want %h", $time, got, want);
      end
   endtask
   task automatic chk_cnt(input int got, input int lo, input int hi);
      n_compared++;
      if (got < lo || got > hi)
      begin
         n_mismatch++;
         $display("[FAIL] %0t got %h want %h..%h", $time, got, lo, hi);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      sfr_addr  <= a;
      sfr_wdata <= d;
      sfr_wr    <= 1'b1;
      @(posedge ref_clk);
      sfr_wr <= 1'b0;
   endtask
   // read result is noted now and compared by the monitor a cycle later
   task automatic rd(input logic [7:0] a, input logic [7:0] want, input bit chained);
      if (!chained)
         @(posedge ref_clk);
      sfr_addr <= a;
      sfr_rd   <= 1'b1;
      exp_q.push_back(want);
      @(posedge ref_clk);
      sfr_rd <= 1'b0;
   endtask
   // pulses counted over a window; ranges absorb the free-running prescaler phase
   task automatic win(input int n, input int lmin, input int lmax, input int hmin, input int hmax);
      int l0;
      int h0;
      l0 = n_lo;
      h0 = n_hi;
      repeat (n) @(posedge ref_clk);
      chk_cnt(n_lo - l0, lmin, lmax);
      chk_cnt(n_hi - h0, hmin, hmax);
   endtask
   always @(posedge ref_clk)
   begin
      pend  <= sfr_rd;
      osc_c <= osc_c + 3'h1;
      if (osc_en)
         ext_osc <= osc_c[2];
      cyc <= cyc + 1;
      if (cyc == 3000)
      begin
         n_mismatch++;
         print_verdict();
      end
   end
   always @(negedge ref_clk)
   begin
      n_lo = n_lo + (ovf_low === 1'b1);
      n_hi = n_hi + (ovf_high === 1'b1);
      if (pend)
         chk_byte(sfr_rdata, exp_q.pop_front());
   end
   initial
   begin
      repeat (10) @(posedge ref_clk);
      rst <= 1'b0;
      rd(tm3_pkg::ADDR_RELOAD_LOW, 8'h00, 0);
      seed = lfsr(seed);
      wr(tm3_pkg::ADDR_RELOAD_LOW, seed[7:0]);
      rd(tm3_pkg::ADDR_RELOAD_LOW, seed[7:0], 1);
      rd(8'h90, 8'h00, 0);
      wr(tm3_pkg::ADDR_COUNT_LOW, 8'h34);
      win(40, 0, 0, 0, 0);
      rd(tm3_pkg::ADDR_COUNT_LOW, 8'h34, 0);
      wr(tm3_pkg::ADDR_RELOAD_HIGH, 8'hff);
      wr(tm3_pkg::ADDR_RELOAD_LOW, 8'hf0);
      wr(tm3_pkg::ADDR_COUNT_HIGH, 8'hff);
      wr(tm3_pkg::ADDR_COUNT_LOW, 8'hf0);
      wr(tm3_pkg::ADDR_CONTROL, 8'h04);
      win(160, 0, 0, 9, 11);
      wr(tm3_pkg::ADDR_CONTROL, 8'h00);
      repeat (3) @(posedge ref_clk);
      win(40, 0, 0, 0, 0);
      wr(tm3_pkg::ADDR_RELOAD_HIGH, 8'hf0);
      wr(tm3_pkg::ADDR_CONTROL, 8'h08);
      win(160, 9, 11, 0, 0);
      clk_sel_low  <= 1'b0;
      clk_sel_high <= 1'b0;
      wr(tm3_pkg::ADDR_RELOAD_LOW, 8'hfe);
      wr(tm3_pkg::ADDR_RELOAD_HIGH, 8'hfe);
      wr(tm3_pkg::ADDR_COUNT_LOW, 8'hfe);
      wr(tm3_pkg::ADDR_COUNT_HIGH, 8'hfe);
      wr(tm3_pkg::ADDR_CONTROL, 8'h0c);
      win(240, 9, 11, 9, 11);
      wr(tm3_pkg::ADDR_RELOAD_LOW, 8'hff);
      osc_en <= 1'b1;
      wr(tm3_pkg::ADDR_CONTROL, 8'h09);
      // low byte starts full so every divided tick overflows
      wr(tm3_pkg::ADDR_COUNT_LOW, 8'hff);
      win(640, 9, 11, 0, 0);
      osc_en <= 1'b0;
      repeat (20) @(posedge ref_clk);
      win(100, 0, 0, 0, 0);
      clk_sel_high <= 1'b1;
      wr(tm3_pkg::ADDR_RELOAD_HIGH, 8'hf0);
      wr(tm3_pkg::ADDR_CONTROL, 8'hfe);
      rd(tm3_pkg::ADDR_CONTROL, 8'h0c, 1);
      win(240, 19, 21, 14, 16);
      print_verdict();
   end
endmodule // tm3_timer_test
